// ==== include/gfc_defs.svh ====
// constants for the four-channel gated frequency counter
// assumes a 40 MHz system clock and a 32-bit register bus
`ifndef GFC_DEFS_SVH
`define GFC_DEFS_SVH

`define GFC_NCH 4
`define GFC_VW 12
`define GFC_VAL_MAX 12'hFFF
`define GFC_SPAN_MIN 12'h004
`define GFC_SPAN_MAX 12'hBB8

`define GFC_GATE_MS 1000
`define GFC_CLK_KHZ 40000
`define GFC_GATE_CYC (`GFC_GATE_MS * `GFC_CLK_KHZ)
`define GFC_GW 26

`define GFC_AW 6
`define GFC_OFF_CTRL 6'h00
`define GFC_OFF_STAT 6'h04
`define GFC_OFF_INTEN 6'h08
`define GFC_OFF_INTCLR 6'h0C
`define GFC_OFF_LIM_SEL 2'h1
`define GFC_OFF_VAL_SEL 2'h2

`define GFC_CTRL_EN_LSB 0
`define GFC_CTRL_YIELD_LSB 4
`define GFC_LIM_UP_LSB 0
`define GFC_LIM_LO_LSB 16
`define GFC_VAL_ABOVE_BIT 16
`define GFC_VAL_BELOW_BIT 17
`define GFC_VAL_ZERO_BIT 18

`define GFC_UPPER_RST 12'hBB8
`define GFC_LOWER_RST 12'h000
`define GFC_CTRL_RST 8'h00
`define GFC_INTEN_RST 4'h0

`endif

// ==== include/gfc_pkg.sv ====
// types shared by the gated frequency counter
// assumes gfc_defs.svh is on the include path
`include "gfc_defs.svh"

package gfc_pkg;

  typedef enum logic {GFC_IDLE, GFC_GATE} gfc_state_e;

  typedef struct packed {
    logic above;
    logic below;
    logic zero;
  } gfc_flags_s;

  typedef struct packed {
    logic [`GFC_VW-1:0] upper;
    logic [`GFC_VW-1:0] lower;
  } gfc_lim_s;

  typedef struct packed {
    logic [`GFC_VW-1:0] value;
    gfc_flags_s flags;
  } gfc_res_s;

  typedef gfc_res_s [`GFC_NCH-1:0] gfc_res_t;

endpackage

// ==== logic/gfc_top.sv ====
// four-channel gated frequency counter with avalon-mm register slave
// assumes pulse_i and run_mode_i synchronous to clk_i, bus master honours waitrequest
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "gfc_defs.svh"

module gfc_top #(
  parameter int GATE_CYCLES = `GFC_GATE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [`GFC_NCH-1:0] pulse_i,
  input wire logic run_mode_i,
  input wire logic [`GFC_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output gfc_pkg::gfc_res_t res_o,
  output logic irq_o
);
  import gfc_pkg::*;

  localparam logic [`GFC_GW-1:0] GATE_LAST = `GFC_GW'(GATE_CYCLES - 1);
  localparam int NCH = `GFC_NCH;

  //////////////////////////////////////////////////////////////////////
  // helpers

  function automatic gfc_flags_s flags_of(input logic [`GFC_VW-1:0] v,
                                          input gfc_lim_s lim);
    gfc_flags_s f;
    f.above = (v >= lim.upper);
    f.below = (v <= lim.lower);
    f.zero = (v == `GFC_VW'(0));
    return f;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] lim_word(input gfc_lim_s l);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`GFC_LIM_UP_LSB +: `GFC_VW] = l.upper;
    w[`GFC_LIM_LO_LSB +: `GFC_VW] = l.lower;
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // state

  logic [NCH-1:0] pin_q;
  gfc_state_e st_q [NCH];
  logic [`GFC_GW-1:0] gate_q [NCH];
  logic [`GFC_VW-1:0] cnt_q [NCH];
  logic [NCH-1:0] en_q;
  logic [NCH-1:0] yield_q;
  logic [NCH-1:0] stat_q;
  logic [NCH-1:0] inten_q;
  gfc_lim_s lim_q [NCH];
  gfc_res_t res_q;
  logic irq_q;
  logic wait_q;
  logic [31:0] rdata_q;

  logic [NCH-1:0] act_d;
  logic [NCH-1:0] rise_d;
  logic [NCH-1:0] done_d;
  logic [NCH-1:0] clr_d;
  logic req_d;
  logic wr_acc_d;
  logic [31:0] rd_d;
  logic [31:0] lim_wd_d;
  gfc_lim_s lim_new_d;

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign res_o = res_q;
  assign irq_o = irq_q;

  //////////////////////////////////////////////////////////////////////
  // channel qualification and pulse edges

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      act_d[i] = en_q[i] & run_mode_i & ~yield_q[i];
      rise_d[i] = pulse_i[i] & ~pin_q[i];
      done_d[i] = (st_q[i] == GFC_GATE) && act_d[i] && (gate_q[i] == GATE_LAST);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_q <= '0;
    end else begin
      pin_q <= pulse_i;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // gate timer and pulse counting

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NCH; i++) begin
        st_q[i] <= GFC_IDLE;
        gate_q[i] <= '0;
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        case (st_q[i])
          GFC_IDLE: begin
            gate_q[i] <= '0;
            cnt_q[i] <= '0;
            if (act_d[i]) begin
              st_q[i] <= GFC_GATE;
            end
          end
          GFC_GATE: begin
            if (!act_d[i]) begin
              st_q[i] <= GFC_IDLE;
              gate_q[i] <= '0;
              cnt_q[i] <= '0;
            end else if (done_d[i]) begin
              gate_q[i] <= '0;
              cnt_q[i] <= rise_d[i] ? `GFC_VW'(1) : `GFC_VW'(0);
            end else begin
              gate_q[i] <= gate_q[i] + `GFC_GW'(1);
              if (rise_d[i] && (cnt_q[i] != `GFC_VAL_MAX)) begin
                cnt_q[i] <= cnt_q[i] + `GFC_VW'(1);
              end
            end
          end
          default: begin
            st_q[i] <= GFC_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // published value and comparison flags

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NCH; i++) begin
        res_q[i].value <= '0;
        res_q[i].flags <= flags_of(`GFC_VW'(0), '{`GFC_UPPER_RST, `GFC_LOWER_RST});
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!act_d[i]) begin
          res_q[i].value <= '0;
          res_q[i].flags <= flags_of(`GFC_VW'(0), lim_q[i]);
        end else if (done_d[i]) begin
          res_q[i].value <= cnt_q[i];
          res_q[i].flags <= flags_of(cnt_q[i], lim_q[i]);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register bus

  always_comb begin
    req_d = avs_read_i | avs_write_i;
    wr_acc_d = avs_write_i & ~wait_q;
    lim_wd_d = be_merge(lim_word(lim_q[avs_address_i[3:2]]), avs_writedata_i,
                        avs_byteenable_i);
    lim_new_d.upper = lim_wd_d[`GFC_LIM_UP_LSB +: `GFC_VW];
    lim_new_d.lower = lim_wd_d[`GFC_LIM_LO_LSB +: `GFC_VW];
    rd_d = 32'h0000_0000;
    case (avs_address_i[5:4])
      2'h0: begin
        case (avs_address_i)
          `GFC_OFF_CTRL: begin
            rd_d[`GFC_CTRL_EN_LSB +: NCH] = en_q;
            rd_d[`GFC_CTRL_YIELD_LSB +: NCH] = yield_q;
          end
          `GFC_OFF_STAT: rd_d[NCH-1:0] = stat_q;
          `GFC_OFF_INTEN: rd_d[NCH-1:0] = inten_q;
          default: rd_d = 32'h0000_0000;
        endcase
      end
      `GFC_OFF_LIM_SEL: rd_d = lim_word(lim_q[avs_address_i[3:2]]);
      `GFC_OFF_VAL_SEL: begin
        rd_d[`GFC_VW-1:0] = res_q[avs_address_i[3:2]].value;
        rd_d[`GFC_VAL_ABOVE_BIT] = res_q[avs_address_i[3:2]].flags.above;
        rd_d[`GFC_VAL_BELOW_BIT] = res_q[avs_address_i[3:2]].flags.below;
        rd_d[`GFC_VAL_ZERO_BIT] = res_q[avs_address_i[3:2]].flags.zero;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~(req_d & wait_q);
      if (avs_read_i && wait_q) begin
        rdata_q <= rd_d;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    logic [31:0] cw;
    logic [31:0] iw;
    cw = 32'h0000_0000;
    iw = 32'h0000_0000;
    if (!rst_b_i) begin
      en_q <= NCH'(`GFC_CTRL_RST);
      yield_q <= '0;
      inten_q <= `GFC_INTEN_RST;
      for (int i = 0; i < NCH; i++) begin
        lim_q[i] <= '{`GFC_UPPER_RST, `GFC_LOWER_RST};
      end
    end else if (wr_acc_d) begin
      cw[`GFC_CTRL_EN_LSB +: NCH] = en_q;
      cw[`GFC_CTRL_YIELD_LSB +: NCH] = yield_q;
      cw = be_merge(cw, avs_writedata_i, avs_byteenable_i);
      if (avs_address_i == `GFC_OFF_CTRL) begin
        en_q <= cw[`GFC_CTRL_EN_LSB +: NCH];
        yield_q <= cw[`GFC_CTRL_YIELD_LSB +: NCH];
      end
      if (avs_address_i == `GFC_OFF_INTEN) begin
        iw = be_merge({28'h0, inten_q}, avs_writedata_i, avs_byteenable_i);
        inten_q <= iw[NCH-1:0];
      end
      if (avs_address_i[5:4] == `GFC_OFF_LIM_SEL) begin
        lim_q[avs_address_i[3:2]] <= lim_new_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // result events and interrupt

  always_comb begin
    clr_d = '0;
    if (wr_acc_d && (avs_address_i == `GFC_OFF_INTCLR) && avs_byteenable_i[0]) begin
      clr_d = avs_writedata_i[NCH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr_d) | done_d;
      irq_q <= |(stat_q & inten_q);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  //////////////////////////////////////////////////////////////////////
  // gate age kept apart from the gate timer

  logic [`GFC_GW-1:0] age_q [NCH];

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rst_b_i || !act_d[i] || (st_q[i] != GFC_GATE) || done_d[i]) begin
        age_q[i] <= '0;
      end else begin
        age_q[i] <= age_q[i] + `GFC_GW'(1);
      end
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    a_value_off_zero: assert property (!act_d[g] |=> res_q[g].value == '0)
      else $error("value not cleared while channel inactive");
    a_above_upper: assert property (done_d[g] |=>
      res_q[g].flags.above == ($past(cnt_q[g]) >= $past(lim_q[g].upper)))
      else $error("above flag wrong after gate");
    a_below_lower: assert property (done_d[g] |=>
      res_q[g].flags.below == ($past(cnt_q[g]) <= $past(lim_q[g].lower)))
      else $error("below flag wrong after gate");
    a_zero_flag: assert property (res_q[g].flags.zero == (res_q[g].value == '0))
      else $error("zero flag disagrees with value");
    a_publish_only_gate: assert property ($changed(res_q[g].value) |->
      $past(done_d[g]) || $past(!act_d[g]))
      else $error("value changed outside gate end");
    a_gate_restart: assert property (act_d[g] && st_q[g] == GFC_IDLE |=>
      st_q[g] == GFC_GATE && gate_q[g] == '0 && cnt_q[g] == '0)
      else $error("gate did not restart at enable");
    a_pulse_step: assert property (st_q[g] == GFC_GATE && act_d[g] && !done_d[g]
      && rise_d[g] && cnt_q[g] != `GFC_VAL_MAX |=> cnt_q[g] == $past(cnt_q[g]) + 1'b1)
      else $error("pulse on own input not counted");
    a_yield_idle: assert property (yield_q[g] |=> st_q[g] == GFC_IDLE)
      else $error("claimed channel still measuring");
    a_gate_len: assert property (done_d[g] |-> age_q[g] == GATE_LAST)
      else $error("gate ended early");
    a_gate_bound: assert property (st_q[g] == GFC_GATE && act_d[g] |->
      age_q[g] <= GATE_LAST) else $error("gate ran past its length");
    a_gate_clear: assert property (done_d[g] && !rise_d[g] |=>
      cnt_q[g] == '0 && gate_q[g] == '0) else $error("count not restarted at gate end");
    a_count_off: assert property (!act_d[g] |=>
      cnt_q[g] == '0 && gate_q[g] == '0) else $error("counting while channel inactive");
    a_run_gate: assert property (!run_mode_i |=>
      res_q[g].value == '0 && st_q[g] == GFC_IDLE) else $error("measuring outside run mode");
    a_flags_hold: assert property (act_d[g] && !done_d[g] |=> $stable(res_q[g]))
      else $error("result moved inside a gate");
    a_stat_set: assert property (done_d[g] |=> stat_q[g])
      else $error("status not set at gate end");
    a_idle_flags: assert property (!act_d[g] |=> res_q[g].flags.below &&
      res_q[g].flags.above == ($past(lim_q[g].upper) == '0))
      else $error("idle flags do not track limits");
    a_pulse_own: assert property (st_q[g] == GFC_GATE && act_d[g] && !done_d[g]
      && !rise_d[g] |=> cnt_q[g] == $past(cnt_q[g]))
      else $error("count moved without own pulse");
    a_yield_value: assert property (yield_q[g] |=> res_q[g].value == '0)
      else $error("claimed channel shows a value");
    a_first_wait: assert property ($rose(act_d[g]) |=> res_q[g].value == '0)
      else $error("value published before first gate");
    a_enable_start: assert property ($rose(act_d[g]) |-> st_q[g] == GFC_IDLE)
      else $error("gate not restarted at enable");
    a_pin_track: assert property (pin_q[g] == $past(pulse_i[g]))
      else $error("edge detector lost its input");
    c_publish: cover property (done_d[g] ##1 res_q[g].value != '0);
    c_yield: cover property (yield_q[g] && en_q[g]);
    c_drop: cover property (done_d[g] ##[1:20] !act_d[g]);
  end

  a_irq_level: assert property (irq_q == $past(|(stat_q & inten_q)))
    else $error("interrupt level wrong");
  c_irq: cover property ($rose(irq_q));
  c_read_val: cover property (avs_read_i && !wait_q && avs_address_i[5:4] == 2'h2);

endmodule

// ==== testbench/gfc_pulse_src.sv ====
// burst pulse source standing on the four counter inputs
// assumes go_i is a one-cycle strobe and cnt_i holds one byte per channel
`timescale 1ns/1ps

module gfc_pulse_src (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic go_i,
  input wire logic [31:0] cnt_i,
  output logic [3:0] pulse_o
);
  logic [7:0] rem_q [4];
  logic [1:0] ph_q [4];

  ////////////////////////////////////////////////////////////
  // one rising edge every four cycles, line low between bursts
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pulse_o <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        rem_q[i] <= 8'h00;
        ph_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (go_i) begin
          rem_q[i] <= cnt_i[8*i +: 8];
        end else if (rem_q[i] != 8'h00) begin
          ph_q[i] <= ph_q[i] + 2'h1;
          pulse_o[i] <= (ph_q[i] == 2'h1);
          if (ph_q[i] == 2'h3) begin
            rem_q[i] <= rem_q[i] - 8'h01;
          end
        end else begin
          pulse_o[i] <= 1'b0;
        end
      end
    end
  end
endmodule

// ==== testbench/tb.sv ====
// directed bench for the gated frequency counter
// assumes gfc_top with a shortened gate and the burst pulse source
`timescale 1ns/1ps
`include "gfc_defs.svh"

module tb;
  import gfc_pkg::*;
  localparam int G = 100;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic run_mode_i = 1'b1;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  gfc_res_t res_o;
  logic irq_o;
  logic [3:0] pulse_i;
  logic go = 1'b0;
  logic [31:0] cnt = 32'h0;
  logic [31:0] rd;
  int num_errors = 0;
  int n_checks = 0;
  int n;

  always #12.5 clk_i = ~clk_i;

  gfc_top #(.GATE_CYCLES(G)) gfc_top_inst (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pulse_i(pulse_i),
    .run_mode_i(run_mode_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .res_o(res_o),
    .irq_o(irq_o)
  );

  gfc_pulse_src gfc_pulse_src_inst (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .go_i(go),
    .cnt_i(cnt),
    .pulse_o(pulse_i)
  );

  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (k >= 50) chk(32'h0, 32'h1);
  endtask

  task automatic chv(input int i, input logic [11:0] v, input logic [11:0] up,
                     input logic [11:0] lo);
    chk({17'h0, res_o[i]}, {17'h0, v, v >= up, v <= lo, v == 12'h000});
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20 * G + 2000) @(posedge clk_i);
    $display("[ERR] %0t watchdog", $time);
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 4; i++) chv(i, 12'h000, 12'hBB8, 12'h000);
    bus(1'b0, 6'h10, 32'h0);
    chk(rd, 32'h0000_0BB8);
    bus(1'b0, 6'h3C, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) bus(1'b1, 6'(16 + 4 * i), 32'h0002_0005);
    bus(1'b1, 6'h08, 32'hF);
    cnt <= 32'h0300_0205;
    bus(1'b1, 6'h00, 32'hF);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (40) @(posedge clk_i);
    chv(0, 12'h000, 12'h005, 12'h002);
    n = 0;
    while (irq_o !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n), 32'(G - 38));
    for (int i = 0; i < 4; i++) begin
      chv(i, 12'(cnt[8*i +: 8]), 12'h005, 12'h002);
    end
    bus(1'b0, 6'h20, 32'h0);
    chk(rd, 32'h0001_0005);
    bus(1'b0, 6'h24, 32'h0);
    chk(rd, 32'h0002_0002);
    avs_byteenable_i <= 4'h1;
    bus(1'b1, 6'h1C, 32'h0BB8_0BB8);
    avs_byteenable_i <= 4'hF;
    bus(1'b0, 6'h1C, 32'h0);
    chk(rd, 32'h0002_00B8);
    bus(1'b0, 6'h04, 32'h0);
    chk(rd, 32'hF);
    bus(1'b1, 6'h0C, 32'hF);
    bus(1'b0, 6'h04, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq_o), 32'h0);
    bus(1'b1, 6'h00, 32'h0);
    repeat (2) @(posedge clk_i);
    chv(0, 12'h000, 12'h005, 12'h002);
    bus(1'b1, 6'h08, 32'h0);
    cnt <= 32'h0000_0005;
    for (int k = 0; k < 3; k++) begin
      run_mode_i <= (k != 0);
      bus(1'b1, 6'h0C, 32'hF);
      bus(1'b1, 6'h00, (k == 1) ? 32'h11 : 32'h1);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (G + 20) @(posedge clk_i);
      chv(0, (k == 2) ? 12'h005 : 12'h000, 12'h005, 12'h002);
      bus(1'b0, 6'h04, 32'h0);
      chk(rd, (k == 2) ? 32'h1 : 32'h0);
      chk(32'(irq_o), 32'h0);
      if (k == 2) begin
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        chv(0, 12'h000, 12'hBB8, 12'h000);
      end
      bus(1'b1, 6'h00, 32'h0);
    end
    stop_test();
  end
endmodule
